// [rtl/tmb_defines.svh]
`ifndef TMB_DEFINES_SVH
`define TMB_DEFINES_SVH

// ****************************************
// Pointer values
// ****************************************
`define TMB_PTR_LOC_MSB 8'h00
`define TMB_PTR_REM_MSB 8'h01
`define TMB_PTR_STATUS 8'h02
`define TMB_PTR_LHI_RD 8'h05
`define TMB_PTR_LLO_RD 8'h06
`define TMB_PTR_RHI_RD 8'h07
`define TMB_PTR_RLO_RD 8'h08
`define TMB_PTR_LHI_WR 8'h0b
`define TMB_PTR_LLO_WR 8'h0c
`define TMB_PTR_RHI_WR 8'h0d
`define TMB_PTR_RLO_WR 8'h0e
`define TMB_PTR_REM_LSB 8'h10
`define TMB_PTR_RHI_LSB 8'h13
`define TMB_PTR_RLO_LSB 8'h14
`define TMB_PTR_LOC_LSB 8'h15
`define TMB_PTR_LHI_LSB 8'h16
`define TMB_PTR_LLO_LSB 8'h17
`define TMB_PTR_RTRIP 8'h19
`define TMB_PTR_LTRIP 8'h20
`define TMB_PTR_HYST 8'h21

// ****************************************
// Reset values
// ****************************************
`define TMB_RST_PTR 8'h00
`define TMB_RST_HI_MSB 8'h55
`define TMB_RST_LO_MSB 8'h00
`define TMB_RST_LSB 4'h0
`define TMB_RST_TRIP 8'h55
`define TMB_RST_HYST 8'h0a
`define TMB_RST_RESULT 12'h000

// ****************************************
// Status bit positions
// ****************************************
`define TMB_ST_BUSY 7
`define TMB_ST_LOVER 6
`define TMB_ST_LUNDER 5
`define TMB_ST_ROVER 4
`define TMB_ST_RUNDER 3
`define TMB_ST_OPEN 2
`define TMB_ST_RTRIP 1
`define TMB_ST_LTRIP 0

// ****************************************
// Limit slots and range
// ****************************************
`define TMB_LIM_LHI 0
`define TMB_LIM_LLO 1
`define TMB_LIM_RHI 2
`define TMB_LIM_RLO 3
`define TMB_STD_MAX 12'h7f0

`endif

// [rtl/tmb_pkg.sv]
package tmb_pkg;

	// ****************************************
	// Channel comparator state
	// ****************************************
	typedef struct packed {
		logic [2:0] cnt;
		logic over_live;
		logic under_live;
		logic over_hys;
		logic trip;
		logic over_hit;
		logic under_hit;
	} tmb_chan_t;

	// ****************************************
	// Register bank state
	// ****************************************
	typedef struct packed {
		logic [7:0] ptr;
		logic wr_more;
		logic [3:0][7:0] lim_msb;
		logic [3:0][3:0] lim_lsb;
		logic [7:0] ltrip_lim;
		logic [7:0] rtrip_lim;
		logic [7:0] hyst;
		logic [11:0] loc_res;
		logic [11:0] rem_res;
		logic [3:0] snap;
		logic [1:0] snap_sel;
		logic [7:0] rd_data;
		logic [7:0] rd_src;
		logic loc_over;
		logic loc_under;
		logic rem_over;
		logic rem_under;
		logic open;
		logic open_live;
		logic [4:0] prev;
		logic alert;
	} tmb_state_t;

endpackage

// [rtl/tmb_channel_cmp.sv]
`include "tmb_defines.svh"

module tmb_channel_cmp
	import tmb_pkg::*;
#(
	parameter int W = 12,
	parameter int CNT_W = 3
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// New conversion
	input wire logic done_i,
	input wire logic [W-1:0] temp_i,
	// Limits
	input wire logic [W-1:0] high_i,
	input wire logic [W-1:0] low_i,
	input wire logic [7:0] trip_i,
	input wire logic [7:0] hyst_i,
	input wire logic [CNT_W-1:0] consec_i,
	// Comparator results
	output logic over_live_o,
	output logic under_live_o,
	output logic over_hys_o,
	output logic trip_o,
	output logic over_hit_o,
	output logic under_hit_o
);

	// Only the documented widths are served
	if (W != 12 || CNT_W != 3) begin
		$error("tmb_channel_cmp: W must be 12 and CNT_W 3");
	end

	tmb_chan_t s_reg, s_next;
	logic [7:0] t_msb;
	logic [7:0] trip_rel;
	logic [W-1:0] hi_rel;
	logic [W-1:0] hyst_w;
	logic over, under, reached;
	logic [CNT_W-1:0] need;

	always_comb begin
		s_next = s_reg;
		t_msb = temp_i[W-1:W-8];
		trip_rel = (trip_i > hyst_i) ? trip_i - hyst_i : 8'h00;
		hyst_w = {hyst_i, 4'h0};
		hi_rel = (high_i > hyst_w) ? high_i - hyst_w : 12'h000;
		over = temp_i > high_i;
		under = temp_i < low_i;
		need = (consec_i == 3'h0) ? 3'h1 : consec_i;
		reached = (s_reg.cnt == 3'h7) || ((s_reg.cnt + 3'h1) >= need);
		s_next.over_hit = 1'b0;
		s_next.under_hit = 1'b0;
		if (done_i) begin
			s_next.over_live = over;
			s_next.under_live = under;
			if (over || under) begin
				if (s_reg.cnt != 3'h7)
					s_next.cnt = s_reg.cnt + 3'h1;
			end else begin
				s_next.cnt = 3'h0;
			end
			s_next.over_hit = over && reached;
			s_next.under_hit = under && reached;
			if (t_msb > trip_i)
				s_next.trip = 1'b1;
			else if (t_msb <= trip_rel)
				s_next.trip = 1'b0;
			if (over)
				s_next.over_hys = 1'b1;
			else if (temp_i <= hi_rel)
				s_next.over_hys = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign over_live_o = s_reg.over_live;
	assign under_live_o = s_reg.under_live;
	assign over_hys_o = s_reg.over_hys;
	assign trip_o = s_reg.trip;
	assign over_hit_o = s_reg.over_hit;
	assign under_hit_o = s_reg.under_hit;

endmodule

// [rtl/tmb_register_bank.sv]
// Operation
// - Pointer is 8 bits, loaded by first write byte, zero after reset.
// - Local result high byte at 00h, low at 15h, read only.
// - Remote result high at 01h, low at 10h, refreshed, reset zero.
// - Low byte read matches the conversion of the preceding high read.
// - Two-byte read from 00h or 01h gives high then low, same conversion.
// - Local high limit written 0Bh/16h, high byte read at 05h.
// - Local low limit written 0Ch/17h, high byte read at 06h.
// - Remote high limit written 0Dh/13h, high byte read at 07h.
// - Remote low limit written 0Eh/14h, high byte read at 08h.
// - High limit high bytes reset to 55h, low limit high bytes to 00h.
// - Trip limits at 20h local and 19h remote, read-write, reset 55h.
// - Shared unsigned trip hysteresis at 21h, reset 0Ah.
// - Limits are never reformatted when the range changes.
// - Status at 02h, top bit shows conversion busy.
// - Diode fault bit 2 set only on remote conversion attempts.
// - Trip bits 1 and 0 follow trip limit with shared hysteresis.
// - Over bits 6 and 4 latch in alert mode, hysteresis in trip mode.
// - Under bits 5 and 3 latch on low limit in either mode.
// - Latched bits clear on status read only once cause has ended.
// - Live bits ignore status reads, update at conversion end.
// - In alert mode a rising latched flag pulls alert low.
// - Status read does not release alert; alert response does.
// - Mode bit zero: alert after consecutive count; one: second trip.
// - Range bit selects extended or standard result format.

`include "tmb_defines.svh"

module tmb_register_bank
	import tmb_pkg::*;
#(
	parameter int RES_W = 12,
	parameter int CNT_W = 3
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Byte port from the serial front end
	input wire logic wr_stb_i,
	input wire logic wr_first_i,
	input wire logic [7:0] wr_byte_i,
	input wire logic rd_stb_i,
	input wire logic rd_first_i,
	input wire logic rd_done_i,
	output logic [7:0] rd_data_o,
	// Converter
	input wire logic busy_i,
	input wire logic local_done_i,
	input wire logic [RES_W-1:0] local_result_i,
	input wire logic remote_done_i,
	input wire logic [RES_W-1:0] remote_result_i,
	input wire logic remote_open_i,
	// Configuration
	input wire logic alert_or_trip_mode_bit_i,
	input wire logic range_ext_i,
	input wire logic alert_mask_i,
	input wire logic [CNT_W-1:0] consec_count_i,
	input wire logic ara_i,
	// Open-drain pins
	output logic thermal_trip_output_o,
	output logic thermal_trip_output_oe_n_o,
	output logic alert_pin_o,
	output logic alert_pin_oe_n_o
);

	// Only the documented widths are served
	if (RES_W != 12 || CNT_W != 3) begin
		$error("tmb_register_bank: RES_W must be 12 and CNT_W 3");
	end

	// ****************************************
	// Declarations
	// ****************************************
	tmb_state_t s_reg, s_next;
	logic l_over_live, l_under_live, l_over_hys, l_trip, l_over_hit;
	logic l_under_hit;
	logic r_over_live, r_under_live, r_over_hys, r_trip, r_over_hit;
	logic r_under_hit;
	logic [RES_W-1:0] loc_val, rem_val;
	logic [RES_W-1:0] lim_full [4];
	logic [7:0] status_byte;
	logic [7:0] rd_addr, wr_addr;
	logic [7:0] rd_val;
	logic mode;
	logic clr;
	logic [4:0] flags;

	// ****************************************
	// Second-byte address of a pair
	// ****************************************
	function automatic logic [7:0] lsb_alias(input logic [7:0] p);
		logic [7:0] a;
		a = p;
		case (p)
			`TMB_PTR_LOC_MSB: a = `TMB_PTR_LOC_LSB;
			`TMB_PTR_REM_MSB: a = `TMB_PTR_REM_LSB;
			`TMB_PTR_LHI_RD, `TMB_PTR_LHI_WR: a = `TMB_PTR_LHI_LSB;
			`TMB_PTR_LLO_RD, `TMB_PTR_LLO_WR: a = `TMB_PTR_LLO_LSB;
			`TMB_PTR_RHI_RD, `TMB_PTR_RHI_WR: a = `TMB_PTR_RHI_LSB;
			`TMB_PTR_RLO_RD, `TMB_PTR_RLO_WR: a = `TMB_PTR_RLO_LSB;
			default: a = p;
		endcase
		return a;
	endfunction

	// ****************************************
	// Result formatting
	// ****************************************
	always_comb begin
		loc_val = local_result_i;
		rem_val = remote_result_i;
		if (!range_ext_i) begin
			if (local_result_i > `TMB_STD_MAX)
				loc_val = `TMB_STD_MAX;
			if (remote_result_i > `TMB_STD_MAX)
				rem_val = `TMB_STD_MAX;
		end
	end

	// Limits are compared as stored, whatever the range
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lim_full[i] = {s_reg.lim_msb[i], s_reg.lim_lsb[i]};
		end
	end

	// ****************************************
	// Channel comparators
	// ****************************************
	tmb_channel_cmp #(
		.W(RES_W),
		.CNT_W(CNT_W)
	) u_local_cmp (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.done_i(local_done_i),
		.temp_i(loc_val),
		.high_i(lim_full[`TMB_LIM_LHI]),
		.low_i(lim_full[`TMB_LIM_LLO]),
		.trip_i(s_reg.ltrip_lim),
		.hyst_i(s_reg.hyst),
		.consec_i(consec_count_i),
		.over_live_o(l_over_live),
		.under_live_o(l_under_live),
		.over_hys_o(l_over_hys),
		.trip_o(l_trip),
		.over_hit_o(l_over_hit),
		.under_hit_o(l_under_hit)
	);

	tmb_channel_cmp #(
		.W(RES_W),
		.CNT_W(CNT_W)
	) u_remote_cmp (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.done_i(remote_done_i),
		.temp_i(rem_val),
		.high_i(lim_full[`TMB_LIM_RHI]),
		.low_i(lim_full[`TMB_LIM_RLO]),
		.trip_i(s_reg.rtrip_lim),
		.hyst_i(s_reg.hyst),
		.consec_i(consec_count_i),
		.over_live_o(r_over_live),
		.under_live_o(r_under_live),
		.over_hys_o(r_over_hys),
		.trip_o(r_trip),
		.over_hit_o(r_over_hit),
		.under_hit_o(r_under_hit)
	);

	// ****************************************
	// Status byte
	// ****************************************
	assign mode = alert_or_trip_mode_bit_i;

	always_comb begin
		status_byte = 8'h00;
		status_byte[`TMB_ST_BUSY] = busy_i;
		status_byte[`TMB_ST_LOVER] = mode ? l_over_hys : s_reg.loc_over;
		status_byte[`TMB_ST_LUNDER] = s_reg.loc_under;
		status_byte[`TMB_ST_ROVER] = mode ? r_over_hys : s_reg.rem_over;
		status_byte[`TMB_ST_RUNDER] = s_reg.rem_under;
		status_byte[`TMB_ST_OPEN] = s_reg.open;
		status_byte[`TMB_ST_RTRIP] = r_trip;
		status_byte[`TMB_ST_LTRIP] = l_trip;
	end

	// ****************************************
	// Read multiplexer
	// ****************************************
	always_comb begin
		rd_addr = rd_first_i ? s_reg.ptr : lsb_alias(s_reg.ptr);
		rd_val = 8'h00;
		case (rd_addr)
			`TMB_PTR_LOC_MSB: rd_val = s_reg.loc_res[11:4];
			`TMB_PTR_REM_MSB: rd_val = s_reg.rem_res[11:4];
			`TMB_PTR_STATUS: rd_val = status_byte;
			`TMB_PTR_LHI_RD: rd_val = s_reg.lim_msb[`TMB_LIM_LHI];
			`TMB_PTR_LLO_RD: rd_val = s_reg.lim_msb[`TMB_LIM_LLO];
			`TMB_PTR_RHI_RD: rd_val = s_reg.lim_msb[`TMB_LIM_RHI];
			`TMB_PTR_RLO_RD: rd_val = s_reg.lim_msb[`TMB_LIM_RLO];
			`TMB_PTR_LOC_LSB: begin
				if (s_reg.snap_sel == 2'h1)
					rd_val = {s_reg.snap, 4'h0};
				else
					rd_val = {s_reg.loc_res[3:0], 4'h0};
			end
			`TMB_PTR_REM_LSB: begin
				if (s_reg.snap_sel == 2'h2)
					rd_val = {s_reg.snap, 4'h0};
				else
					rd_val = {s_reg.rem_res[3:0], 4'h0};
			end
			`TMB_PTR_LHI_LSB: rd_val = {s_reg.lim_lsb[`TMB_LIM_LHI], 4'h0};
			`TMB_PTR_LLO_LSB: rd_val = {s_reg.lim_lsb[`TMB_LIM_LLO], 4'h0};
			`TMB_PTR_RHI_LSB: rd_val = {s_reg.lim_lsb[`TMB_LIM_RHI], 4'h0};
			`TMB_PTR_RLO_LSB: rd_val = {s_reg.lim_lsb[`TMB_LIM_RLO], 4'h0};
			`TMB_PTR_RTRIP: rd_val = s_reg.rtrip_lim;
			`TMB_PTR_LTRIP: rd_val = s_reg.ltrip_lim;
			`TMB_PTR_HYST: rd_val = s_reg.hyst;
			default: rd_val = 8'h00;
		endcase
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_next = s_reg;
		wr_addr = s_reg.wr_more ? lsb_alias(s_reg.ptr) : s_reg.ptr;
		clr = rd_done_i && (s_reg.rd_src == `TMB_PTR_STATUS);

		// Write path
		if (wr_stb_i) begin
			if (wr_first_i) begin
				s_next.ptr = wr_byte_i;
				s_next.wr_more = 1'b0;
			end else begin
				s_next.wr_more = 1'b1;
				case (wr_addr)
					`TMB_PTR_LHI_WR: s_next.lim_msb[`TMB_LIM_LHI] = wr_byte_i;
					`TMB_PTR_LLO_WR: s_next.lim_msb[`TMB_LIM_LLO] = wr_byte_i;
					`TMB_PTR_RHI_WR: s_next.lim_msb[`TMB_LIM_RHI] = wr_byte_i;
					`TMB_PTR_RLO_WR: s_next.lim_msb[`TMB_LIM_RLO] = wr_byte_i;
					`TMB_PTR_LHI_LSB: s_next.lim_lsb[`TMB_LIM_LHI] = wr_byte_i[7:4];
					`TMB_PTR_LLO_LSB: s_next.lim_lsb[`TMB_LIM_LLO] = wr_byte_i[7:4];
					`TMB_PTR_RHI_LSB: s_next.lim_lsb[`TMB_LIM_RHI] = wr_byte_i[7:4];
					`TMB_PTR_RLO_LSB: s_next.lim_lsb[`TMB_LIM_RLO] = wr_byte_i[7:4];
					`TMB_PTR_RTRIP: s_next.rtrip_lim = wr_byte_i;
					`TMB_PTR_LTRIP: s_next.ltrip_lim = wr_byte_i;
					`TMB_PTR_HYST: s_next.hyst = wr_byte_i;
					default: s_next.wr_more = 1'b1;
				endcase
			end
		end

		// Read path and coherence snapshot
		if (rd_stb_i) begin
			s_next.rd_data = rd_val;
			s_next.rd_src = rd_addr;
			if (rd_addr == `TMB_PTR_LOC_MSB) begin
				s_next.snap = s_reg.loc_res[3:0];
				s_next.snap_sel = 2'h1;
			end else if (rd_addr == `TMB_PTR_REM_MSB) begin
				s_next.snap = s_reg.rem_res[3:0];
				s_next.snap_sel = 2'h2;
			end else if (rd_addr != `TMB_PTR_LOC_LSB &&
					rd_addr != `TMB_PTR_REM_LSB) begin
				s_next.snap_sel = 2'h0;
			end
		end

		// Conversion results
		if (local_done_i)
			s_next.loc_res = loc_val;
		if (remote_done_i) begin
			s_next.rem_res = rem_val;
			s_next.open_live = remote_open_i;
		end

		// Latched flags: clear first, then set so that a set wins
		if (clr) begin
			if (!l_over_live)
				s_next.loc_over = 1'b0;
			if (!r_over_live)
				s_next.rem_over = 1'b0;
			if (!l_under_live)
				s_next.loc_under = 1'b0;
			if (!r_under_live)
				s_next.rem_under = 1'b0;
			if (!s_reg.open_live)
				s_next.open = 1'b0;
		end
		if (l_over_hit && !mode)
			s_next.loc_over = 1'b1;
		if (r_over_hit && !mode)
			s_next.rem_over = 1'b1;
		if (l_under_hit)
			s_next.loc_under = 1'b1;
		if (r_under_hit)
			s_next.rem_under = 1'b1;
		if (remote_done_i && remote_open_i)
			s_next.open = 1'b1;

		// Alert latch: in alert mode set on any rising latched flag, released by response
		flags = {s_next.loc_over & ~mode, s_next.loc_under,
			s_next.rem_over & ~mode, s_next.rem_under, s_next.open};
		s_next.prev = flags;
		if (ara_i)
			s_next.alert = 1'b0;
		if (!mode && (|(flags & ~s_reg.prev)))
			s_next.alert = 1'b1;
		if (mode)
			s_next.alert = 1'b0;
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s_reg <= '0;
			s_reg.ptr <= `TMB_RST_PTR;
			s_reg.lim_msb[`TMB_LIM_LHI] <= `TMB_RST_HI_MSB;
			s_reg.lim_msb[`TMB_LIM_LLO] <= `TMB_RST_LO_MSB;
			s_reg.lim_msb[`TMB_LIM_RHI] <= `TMB_RST_HI_MSB;
			s_reg.lim_msb[`TMB_LIM_RLO] <= `TMB_RST_LO_MSB;
			s_reg.lim_lsb <= {4{`TMB_RST_LSB}};
			s_reg.ltrip_lim <= `TMB_RST_TRIP;
			s_reg.rtrip_lim <= `TMB_RST_TRIP;
			s_reg.hyst <= `TMB_RST_HYST;
			s_reg.loc_res <= `TMB_RST_RESULT;
			s_reg.rem_res <= `TMB_RST_RESULT;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign rd_data_o = s_reg.rd_data;
	assign thermal_trip_output_o = 1'b0;
	assign thermal_trip_output_oe_n_o = ~(l_trip | r_trip);
	assign alert_pin_o = 1'b0;
	always_comb begin
		if (mode)
			alert_pin_oe_n_o = ~(l_over_hys | r_over_hys);
		else
			alert_pin_oe_n_o = ~(s_reg.alert & ~alert_mask_i);
	end

endmodule

// [dv/tmb_monitor.sv]
module tmb_monitor
	import tmb_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Byte port
	input wire logic wr_stb_i,
	input wire logic wr_first_i,
	input wire logic [7:0] wr_byte_i,
	input wire logic rd_stb_i,
	input wire logic rd_first_i,
	input wire logic [7:0] rd_data_o,
	// Converter and configuration
	input wire logic local_done_i,
	input wire logic remote_done_i,
	input wire logic alert_or_trip_mode_bit_i,
	input wire logic alert_mask_i,
	input wire logic ara_i,
	// Pins
	input wire logic thermal_trip_output_o,
	input wire logic thermal_trip_output_oe_n_o,
	input wire logic alert_pin_o,
	input wire logic alert_pin_oe_n_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Pointer copy and conversion history
	// ****************************************
	logic [7:0] ptr_reg;
	logic [3:0] done_reg;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ptr_reg <= 8'h00;
			done_reg <= 4'h0;
		end else begin
			if (wr_stb_i && wr_first_i) begin
				ptr_reg <= wr_byte_i;
			end
			done_reg <= {done_reg[2:0], local_done_i | remote_done_i};
		end
	end

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// ****************************************
	// Properties
	// ****************************************
	property p_pins;
		!thermal_trip_output_o && !alert_pin_o;
	endproperty
	a_pins: assert property (p_pins)
		else $error("open-drain pin value not low");
	property p_rd_hold;
		!rd_stb_i |=> $stable(rd_data_o);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read byte changed without a read strobe");
	property p_unmapped;
		rd_stb_i && rd_first_i && ptr_reg > 8'h21 |=> rd_data_o == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped pointer read not zero");
	property p_trip_change;
		$changed(thermal_trip_output_oe_n_o) |-> done_reg[2:0] != 3'h0;
	endproperty
	a_trip_change: assert property (p_trip_change)
		else $error("trip pin moved without a conversion");
	property p_alert_cause;
		$fell(alert_pin_oe_n_o) && !alert_or_trip_mode_bit_i &&
			$stable(alert_or_trip_mode_bit_i) && $stable(alert_mask_i)
			|-> done_reg != 4'h0;
	endproperty
	a_alert_cause: assert property (p_alert_cause)
		else $error("alert fell without a conversion");
	property p_alert_hold;
		!alert_or_trip_mode_bit_i && !alert_mask_i && !alert_pin_oe_n_o &&
			!ara_i |=> !alert_pin_oe_n_o || alert_mask_i ||
			alert_or_trip_mode_bit_i;
	endproperty
	a_alert_hold: assert property (p_alert_hold)
		else $error("alert released without alert response");
	property p_mask;
		!alert_or_trip_mode_bit_i && alert_mask_i |-> alert_pin_oe_n_o;
	endproperty
	a_mask: assert property (p_mask)
		else $error("masked alert driven low");
	property p_second_trip;
		alert_or_trip_mode_bit_i && $stable(alert_or_trip_mode_bit_i) &&
			$changed(alert_pin_oe_n_o) |-> done_reg != 4'h0;
	endproperty
	a_second_trip: assert property (p_second_trip)
		else $error("second trip output moved without a conversion");
endmodule

bind tmb_register_bank tmb_monitor mon_u (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .wr_stb_i(wr_stb_i),
	.wr_first_i(wr_first_i), .wr_byte_i(wr_byte_i), .rd_stb_i(rd_stb_i),
	.rd_first_i(rd_first_i), .rd_data_o(rd_data_o),
	.local_done_i(local_done_i), .remote_done_i(remote_done_i),
	.alert_or_trip_mode_bit_i(alert_or_trip_mode_bit_i),
	.alert_mask_i(alert_mask_i), .ara_i(ara_i),
	.thermal_trip_output_o(thermal_trip_output_o),
	.thermal_trip_output_oe_n_o(thermal_trip_output_oe_n_o),
	.alert_pin_o(alert_pin_o), .alert_pin_oe_n_o(alert_pin_oe_n_o)
);

// [dv/tmb_host_model.sv]
module tmb_host_model
	import tmb_pkg::*;
(
	// Clock
	input wire logic core_clk_i,
	// Byte port
	input wire logic [7:0] rd_data_i,
	output logic wr_stb_o,
	output logic wr_first_o,
	output logic [7:0] wr_byte_o,
	output logic rd_stb_o,
	output logic rd_first_o,
	output logic rd_done_o,
	output logic ara_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Byte transfers
	// ****************************************
	initial begin
		{wr_stb_o, wr_first_o, rd_stb_o, rd_first_o, rd_done_o, ara_o} = 6'h00;
		wr_byte_o = 8'h00;
	end
	task pulse(input logic [5:0] s, input logic [7:0] b);
		@(posedge core_clk_i);
		#1;
		{wr_stb_o, wr_first_o, rd_stb_o, rd_first_o, rd_done_o, ara_o} = s;
		wr_byte_o = b;
		@(posedge core_clk_i);
		#1;
		{wr_stb_o, wr_first_o, rd_stb_o, rd_first_o, rd_done_o, ara_o} = 6'h00;
		wr_byte_o = ~b;
	endtask
	task write(input logic [7:0] p, input int n, input logic [7:0] d0, d1);
		pulse(6'b110000, p);
		if (n > 0) pulse(6'b100000, d0);
		if (n > 1) pulse(6'b100000, d1);
	endtask
	task read(input logic [7:0] p, input int n, output logic [7:0] q0, q1);
		pulse(6'b110000, p);
		pulse(6'b001100, 8'h00);
		q0 = rd_data_i;
		pulse(6'b000010, 8'h00);
		q1 = 8'h00;
		if (n > 1) begin
			pulse(6'b001000, 8'h00);
			q1 = rd_data_i;
			pulse(6'b000010, 8'h00);
		end
	endtask
	task alert_response;
		pulse(6'b000001, 8'h00);
	endtask
endmodule

// [dv/tmb_register_bank_test.sv]
module tmb_register_bank_test
	import tmb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Signals and instances
	// ****************************************
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wr_stb, wr_first, rd_stb, rd_first, rd_done, ara;
	logic [7:0] wr_byte, rd_data, q0, q1;
	logic busy = 1'b0, ldone = 1'b0, rdone = 1'b0, ropen = 1'b0;
	logic mode = 1'b0, range_ext = 1'b0, mask = 1'b0;
	logic [2:0] consec = 3'h0;
	logic [11:0] lres = 12'h000, rres = 12'h000;
	logic tt_o, tt_oe_n, al_o, al_oe_n;
	logic [39:0] r;
	int error_cnt = 0;
	int total_checks = 0;
	logic [39:0] rows [18] = '{
		40'h0b05553030, 40'h0c06001010, 40'h0d07554040, 40'h0e08000808,
		40'h161600f0f0, 40'h1717003530, 40'h1313000f00, 40'h1414008080,
		40'h1919555050, 40'h2020553c3c, 40'h21210a0505, 40'h0000005a00,
		40'h0101005a00, 40'h020200ff00, 40'h1010005a00, 40'h1515005a00,
		40'h303000ff00, 40'h0505301130};

	always #5 core_clk_i = ~core_clk_i;

	tmb_register_bank dut_u (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.wr_stb_i(wr_stb), .wr_first_i(wr_first), .wr_byte_i(wr_byte),
		.rd_stb_i(rd_stb), .rd_first_i(rd_first), .rd_done_i(rd_done),
		.rd_data_o(rd_data), .busy_i(busy),
		.local_done_i(ldone), .local_result_i(lres),
		.remote_done_i(rdone), .remote_result_i(rres),
		.remote_open_i(ropen), .alert_or_trip_mode_bit_i(mode),
		.range_ext_i(range_ext), .alert_mask_i(mask),
		.consec_count_i(consec), .ara_i(ara),
		.thermal_trip_output_o(tt_o), .thermal_trip_output_oe_n_o(tt_oe_n),
		.alert_pin_o(al_o), .alert_pin_oe_n_o(al_oe_n)
	);
	tmb_host_model host_u (
		.core_clk_i(core_clk_i), .rd_data_i(rd_data),
		.wr_stb_o(wr_stb), .wr_first_o(wr_first), .wr_byte_o(wr_byte),
		.rd_stb_o(rd_stb), .rd_first_o(rd_first), .rd_done_o(rd_done),
		.ara_o(ara)
	);

	// ****************************************
	// Helpers
	// ****************************************
	task chk(input string n, input logic [7:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task pins(input logic et, ea);
		chk("trip_oe_n", {7'h00, tt_oe_n}, {7'h00, et});
		chk("alert_oe_n", {7'h00, al_oe_n}, {7'h00, ea});
		chk("pin_levels", {6'h00, tt_o, al_o}, 8'h00);
	endtask
	task rdv(input logic [7:0] p, e);
		host_u.read(p, 1, q0, q1);
		chk($sformatf("reg %h", p), q0, e);
	endtask
	task rd2(input logic [7:0] p, e0, e1);
		host_u.read(p, 2, q0, q1);
		chk($sformatf("high %h", p), q0, e0);
		chk($sformatf("low %h", p), q1, e1);
	endtask
	task tick;
		@(posedge core_clk_i);
		#1;
	endtask
	task conv(input logic rem, input logic [11:0] v, input logic op);
		tick;
		{ldone, rdone, ropen} = {!rem, rem, op};
		{lres, rres} = {v, v};
		tick;
		{ldone, rdone, ropen} = {2'b00, !op};
		{lres, rres} = {~v, ~v};
		repeat (4) tick;
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge core_clk_i);
		error_cnt++;
		$display("BAD watchdog expected end seen hang");
		finish_test;
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (20) tick;
		chk("rd_data", rd_data, 8'h00);
		pins(1'b1, 1'b1);
		rst_n_i = 1'b1;
		for (int i = 0; i < 18; i++) begin
			r = rows[i];
			rdv(r[31:24], r[23:16]);
			host_u.write(r[39:32], 1, r[15:8], 8'h00);
			rdv(r[31:24], r[7:0]);
		end
		$display("test rows done");
		host_u.write(8'h0b, 2, 8'h2a, 8'h90);
		rd2(8'h05, 8'h2a, 8'h90);
		conv(1'b0, 12'h40c, 1'b0);
		pins(1'b0, 1'b0);
		rd2(8'h00, 8'h40, 8'hc0);
		rdv(8'h00, 8'h40);
		conv(1'b0, 12'h41f, 1'b0);
		rdv(8'h15, 8'hc0);
		conv(1'b0, 12'h38a, 1'b0);
		rdv(8'h02, 8'h41);
		rdv(8'h15, 8'ha0);
		mask = 1'b1;
		tick;
		pins(1'b0, 1'b1);
		mask = 1'b0;
		tick;
		pins(1'b0, 1'b0);
		conv(1'b0, 12'h200, 1'b0);
		rdv(8'h02, 8'h40);
		rdv(8'h02, 8'h00);
		pins(1'b1, 1'b0);
		host_u.alert_response;
		pins(1'b1, 1'b1);
		$display("test local done");
		busy = 1'b1;
		conv(1'b1, 12'h050, 1'b1);
		rdv(8'h02, 8'h8c);
		busy = 1'b0;
		rd2(8'h01, 8'h05, 8'h00);
		pins(1'b1, 1'b0);
		conv(1'b1, 12'h100, 1'b0);
		rdv(8'h02, 8'h0c);
		rdv(8'h02, 8'h00);
		host_u.alert_response;
		pins(1'b1, 1'b1);
		$display("test remote done");
		mode = 1'b1;
		conv(1'b0, 12'h900, 1'b0);
		pins(1'b0, 1'b0);
		rdv(8'h00, 8'h7f);
		range_ext = 1'b1;
		conv(1'b0, 12'h905, 1'b0);
		rd2(8'h00, 8'h90, 8'h50);
		rdv(8'h05, 8'h2a);
		conv(1'b0, 12'h250, 1'b0);
		pins(1'b1, 1'b1);
		rdv(8'h02, 8'h00);
		{mode, range_ext} = 2'b00;
		$display("test second trip done");
		consec = 3'h2;
		conv(1'b0, 12'h010, 1'b0);
		rdv(8'h02, 8'h00);
		pins(1'b1, 1'b1);
		conv(1'b0, 12'h010, 1'b0);
		rdv(8'h02, 8'h20);
		pins(1'b1, 1'b0);
		$display("test consecutive done");
		conv(1'b0, 12'h500, 1'b0);
		rst_n_i = 1'b0;
		repeat (2) tick;
		chk("rd_data", rd_data, 8'h00);
		pins(1'b1, 1'b1);
		rst_n_i = 1'b1;
		rdv(8'h05, 8'h55);
		rdv(8'h21, 8'h0a);
		$display("test reset done");
		finish_test;
	end
endmodule
